// File: hdl/lacc_pkg.sv
/*
 * constants for the load adaptive current control block: register
 * word addresses, field positions, reset values and state encoding.
 * assumes a single 10 MHz system clock and a plain register port.
 */
package lacc_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int unsigned ADDR_W  = 4;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned LOAD_W  = 10;
   localparam int unsigned VEL_W   = 23;
   localparam int unsigned CS_W    = 5;
   localparam int unsigned ZW_W    = 16;

   // ****************************************************************
   // register word addresses
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CFG      = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_CURRENT  = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_VLOW     = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_UPPER_VELOCITY_THRESHOLD    = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_ZWAIT    = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_RAMPSTAT = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_DRVSTAT  = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_ACTUAL_VELOCITY  = 4'h7;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int unsigned CFG_LOW_LSB   = 0;
   localparam int unsigned CFG_OFS_LSB   = 4;
   localparam int unsigned CFG_INC_LSB   = 8;
   localparam int unsigned CFG_DEC_LSB   = 10;
   localparam int unsigned CFG_MIN_BIT   = 12;
   localparam int unsigned CFG_FILT_BIT  = 13;
   localparam int unsigned CFG_STOP_BIT  = 14;
   localparam int unsigned CUR_RUN_LSB   = 0;
   localparam int unsigned CUR_HOLD_LSB  = 8;
   localparam int unsigned RS_EVENT_BIT  = 0;
   localparam int unsigned DS_LOAD_LSB   = 0;
   localparam int unsigned DS_CS_LSB     = 16;
   localparam int unsigned DS_STALL_BIT  = 24;
   localparam int unsigned LOAD_SCALE_SH = 5;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [DATA_W-1:0] CFG_RST     = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CURRENT_RST = 32'h0000_0A1F;
   localparam logic [VEL_W-1:0]  VEL_RST     = 23'h00_0000;
   localparam logic [ZW_W-1:0]   ZWAIT_RST   = 16'h0000;

   // ****************************************************************
   // readings per decrement, indexed by the decrement rate code
   // ****************************************************************
   localparam logic [5:0] DEC_N0 = 6'h20;
   localparam logic [5:0] DEC_N1 = 6'h08;
   localparam logic [5:0] DEC_N2 = 6'h02;
   localparam logic [5:0] DEC_N3 = 6'h01;

   typedef enum logic [1:0] {ST_RUN, ST_STOPPED, ST_ZWAIT} stall_state_t;

endpackage

// File: hdl/load_filter.sv
/*
 * load measurement conditioner: passes each full step measurement,
 * or averages four of them when the filter is enabled.
 * assumes sample_valid_in pulses once per full step.
 */
module load_filter
   import lacc_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rst_b_in,
   // control
   input  wire logic              filter_en_in,
   // raw measurement
   input  wire logic [LOAD_W-1:0] sample_in,
   input  wire logic              sample_valid_in,
   // conditioned measurement
   output logic      [LOAD_W-1:0] load_out,
   output logic                   load_valid_out
);

   logic [LOAD_W+1:0] acc_r;
   logic [1:0]        cnt_r;
   logic [LOAD_W+1:0] sum;

   assign sum = acc_r + {2'b00, sample_in};

   // ****************************************************************
   // accumulate four samples in filtered mode
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in || !filter_en_in) begin
         acc_r <= '0;
         cnt_r <= '0;
      end else if (sample_valid_in) begin
         cnt_r <= cnt_r + 2'h1;
         acc_r <= (cnt_r == 2'h3) ? '0 : sum;
      end
   end

   // ****************************************************************
   // result register and strobe
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         load_out       <= '0;
         load_valid_out <= 1'b0;
      end else begin
         load_valid_out <= 1'b0;
         if (sample_valid_in && !filter_en_in) begin
            load_out       <= sample_in;
            load_valid_out <= 1'b1;
         end else if (sample_valid_in && cnt_r == 2'h3) begin
            load_out       <= sum[LOAD_W+1:2];
            load_valid_out <= 1'b1;
         end
      end
   end

   filt_rate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (filter_en_in && sample_valid_in && cnt_r != 2'h3) |=> !load_valid_out)
      else $error("filtered result issued before fourth sample");

endmodule // load_filter

// File: hdl/load_adaptive_current_control.sv
/*
 * load adaptive coil current regulator with stop on stall.
 * assumes a load measurement strobe once per full step, the ramp
 * generator velocity magnitude as input, and a plain register port
 * whose read data appear the cycle after the read strobe.
 */
module load_adaptive_current_control
   import lacc_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rst_b_in,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   // load measurement
   input  wire logic [LOAD_W-1:0] load_measurement_in,
   input  wire logic              load_valid_in,
   input  wire logic              motor_blocked_in,
   // ramp generator
   input  wire logic [VEL_W-1:0]  ramp_velocity_in,
   input  wire logic              standstill_in,
   input  wire logic              ext_step_mode_in,
   input  wire logic              motion_changed_in,
   output logic                   ramp_halt_out,
   output logic      [VEL_W-1:0]  actual_velocity_out,
   // driver
   output logic      [CS_W-1:0]   coil_scale_out,
   output logic                   stall_flag_out
);

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [DATA_W-1:0] cfg_r;
   logic [DATA_W-1:0] current_r;
   logic [VEL_W-1:0]  vlow_r;
   logic [VEL_W-1:0]  upper_velocity_threshold_r;
   logic [ZW_W-1:0]   zwait_r;

   logic [3:0]        lower_load_threshold;
   logic [3:0]        upper_threshold_offset;
   logic [1:0]        current_increment_step;
   logic [1:0]        current_decrement_rate;
   logic              min_current_sel;
   logic              filter_en;
   logic              stop_on_stall_enable;
   logic [CS_W-1:0]   run_current;
   logic [CS_W-1:0]   hold_current;

   assign lower_load_threshold   = cfg_r[CFG_LOW_LSB +: 4];
   assign upper_threshold_offset = cfg_r[CFG_OFS_LSB +: 4];
   assign current_increment_step = cfg_r[CFG_INC_LSB +: 2];
   assign current_decrement_rate = cfg_r[CFG_DEC_LSB +: 2];
   assign min_current_sel        = cfg_r[CFG_MIN_BIT];
   assign filter_en              = cfg_r[CFG_FILT_BIT];
   assign stop_on_stall_enable   = cfg_r[CFG_STOP_BIT];
   assign run_current            = current_r[CUR_RUN_LSB +: CS_W];
   assign hold_current           = current_r[CUR_HOLD_LSB +: CS_W];

   // ****************************************************************
   // status storage and shared signals
   // ****************************************************************
   stall_state_t      state_r;
   stall_state_t      state_nxt;
   logic [ZW_W-1:0]   zw_cnt_r;
   logic              event_r;
   logic              drv_stall_r;
   logic [CS_W-1:0]   cs_r;
   logic [5:0]        dec_cnt_r;
   logic [VEL_W-1:0]  vact_r;
   logic [LOAD_W-1:0] load;
   logic              load_valid;
   logic              rs_read;
   logic              stall_src;
   logic              stop_set;
   logic              vel_low_ok;
   logic              gate_active;
   logic [LOAD_W:0]   lower_thr;
   logic [LOAD_W:0]   upper_thr;
   logic [CS_W-1:0]   min_cs;
   logic [5:0]        dec_need;

   // ****************************************************************
   // saturating arithmetic on the current scale
   // ****************************************************************
   function automatic logic [CS_W-1:0] sat_up(input logic [CS_W-1:0] v,
                                              input logic [1:0]      st,
                                              input logic [CS_W-1:0] hi);
      logic [CS_W:0] s;
      s = {1'b0, v} + ({{CS_W{1'b0}}, 1'b1} << st);
      return (s > {1'b0, hi}) ? hi : s[CS_W-1:0];
   endfunction

   function automatic logic [CS_W-1:0] sat_dn(input logic [CS_W-1:0] v,
                                              input logic [CS_W-1:0] lo);
      return (v > lo) ? v - {{(CS_W-1){1'b0}}, 1'b1} : lo;
   endfunction

   // ****************************************************************
   // load measurement conditioning
   // ****************************************************************
   load_filter u_filter (
      .clk_sys_in      (clk_sys_in),
      .rst_b_in        (rst_b_in),
      .filter_en_in    (filter_en),
      .sample_in       (load_measurement_in),
      .sample_valid_in (load_valid_in),
      .load_out        (load),
      .load_valid_out  (load_valid)
   );

   // ****************************************************************
   // register writes
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cfg_r     <= CFG_RST;
         current_r <= CURRENT_RST;
         vlow_r    <= VEL_RST;
         upper_velocity_threshold_r   <= VEL_RST;
         zwait_r   <= ZWAIT_RST;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            ADDR_CFG:     cfg_r     <= reg_wdata_in;
            ADDR_CURRENT: current_r <= reg_wdata_in;
            ADDR_VLOW:    vlow_r    <= reg_wdata_in[VEL_W-1:0];
            ADDR_UPPER_VELOCITY_THRESHOLD:   upper_velocity_threshold_r   <= reg_wdata_in[VEL_W-1:0];
            ADDR_ZWAIT:   zwait_r   <= reg_wdata_in[ZW_W-1:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // register reads, data valid only in the cycle after the strobe
   // ****************************************************************
   assign rs_read = reg_rd_in && (reg_addr_in == ADDR_RAMPSTAT);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in || !reg_rd_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= '0;
         unique case (reg_addr_in)
            ADDR_CFG:      reg_rdata_out <= cfg_r;
            ADDR_CURRENT:  reg_rdata_out <= current_r;
            ADDR_VLOW:     reg_rdata_out[VEL_W-1:0] <= vlow_r;
            ADDR_UPPER_VELOCITY_THRESHOLD:    reg_rdata_out[VEL_W-1:0] <= upper_velocity_threshold_r;
            ADDR_ZWAIT:    reg_rdata_out[ZW_W-1:0]  <= zwait_r;
            ADDR_RAMPSTAT: reg_rdata_out[RS_EVENT_BIT] <= event_r;
            ADDR_DRVSTAT: begin
               reg_rdata_out[DS_LOAD_LSB +: LOAD_W] <= load;
               reg_rdata_out[DS_CS_LSB +: CS_W]     <= cs_r;
               reg_rdata_out[DS_STALL_BIT]          <= stall_flag_out;
            end
            ADDR_ACTUAL_VELOCITY:  reg_rdata_out[VEL_W-1:0] <= vact_r;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // stall detection and stop sequencing
   // ****************************************************************
   assign vel_low_ok = ramp_velocity_in >= vlow_r;
   assign stall_src  = (load_valid && load == '0 && vel_low_ok)
                     || motor_blocked_in;
   assign stop_set   = stop_on_stall_enable && stall_src;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: begin
            if (stop_set)
               state_nxt = ST_STOPPED;
         end
         ST_STOPPED: begin
            if (!stop_on_stall_enable)
               state_nxt = ST_RUN;
            else if (rs_read && motion_changed_in)
               state_nxt = ST_RUN;
            else if (rs_read)
               state_nxt = ST_ZWAIT;
         end
         ST_ZWAIT: begin
            if (stop_set)
               state_nxt = ST_STOPPED;
            else if (zw_cnt_r == '0 || !stop_on_stall_enable)
               state_nxt = ST_RUN;
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         zw_cnt_r <= '0;
      end else if (state_r != ST_ZWAIT) begin
         zw_cnt_r <= zwait_r;
      end else if (zw_cnt_r != '0) begin
         zw_cnt_r <= zw_cnt_r - {{(ZW_W-1){1'b0}}, 1'b1};
      end
   end

   // event flag: a new stop wins over a clearing read
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         event_r <= 1'b0;
      end else if (state_r != ST_STOPPED && state_nxt == ST_STOPPED) begin
         event_r <= 1'b1;
      end else if (rs_read) begin
         event_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         drv_stall_r <= 1'b0;
      end else if (motor_blocked_in) begin
         drv_stall_r <= 1'b1;
      end else if (load_valid) begin
         drv_stall_r <= stall_src;
      end
   end

   assign stall_flag_out = drv_stall_r || (state_r == ST_STOPPED);
   assign ramp_halt_out  = (state_r != ST_RUN);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         vact_r <= '0;
      end else begin
         vact_r <= (state_nxt != ST_RUN) ? '0 : ramp_velocity_in;
      end
   end

   assign actual_velocity_out = vact_r;

   // ****************************************************************
   // adaptive current regulation
   // ****************************************************************
   assign gate_active = (lower_load_threshold != 4'h0)
                      && (ext_step_mode_in
                          || (vel_low_ok
                              && ramp_velocity_in <= upper_velocity_threshold_r));
   assign lower_thr = {7'h00, lower_load_threshold} << LOAD_SCALE_SH;
   assign upper_thr = ({7'h00, lower_load_threshold}
                      + {7'h00, upper_threshold_offset}
                      + 11'h001) << LOAD_SCALE_SH;
   assign min_cs    = min_current_sel ? (run_current >> 2)
                                      : (run_current >> 1);

   always_comb begin
      unique case (current_decrement_rate)
         2'h0: dec_need = DEC_N0;
         2'h1: dec_need = DEC_N1;
         2'h2: dec_need = DEC_N2;
         2'h3: dec_need = DEC_N3;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cs_r      <= '0;
         dec_cnt_r <= '0;
      end else if (!gate_active) begin
         cs_r      <= standstill_in ? hold_current : run_current;
         dec_cnt_r <= '0;
      end else if (cs_r > run_current) begin
         cs_r      <= run_current;
      end else if (cs_r < min_cs) begin
         cs_r      <= min_cs;
      end else if (load_valid) begin
         if ({1'b0, load} < lower_thr) begin
            cs_r      <= sat_up(cs_r, current_increment_step,
                                run_current);
            dec_cnt_r <= '0;
         end else if ({1'b0, load} >= upper_thr) begin
            if (dec_cnt_r + 6'h01 >= dec_need) begin
               cs_r      <= sat_dn(cs_r, min_cs);
               dec_cnt_r <= '0;
            end else begin
               dec_cnt_r <= dec_cnt_r + 6'h01;
            end
         end else begin
            dec_cnt_r <= '0;
         end
      end
   end

   assign coil_scale_out = cs_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   stop_entry_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state_r == ST_RUN && stop_set) |=> (state_r == ST_STOPPED && ramp_halt_out
                                            && actual_velocity_out == '0))
      else $error("stall did not stop the ramp");

   stop_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state_r == ST_STOPPED) |-> stall_flag_out && actual_velocity_out == '0)
      else $error("stopped without stall flag or with motion");

   event_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (rs_read && !(state_r != ST_STOPPED && state_nxt == ST_STOPPED))
      |=> !event_r)
      else $error("status read did not clear stop event");

   zero_wait_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state_r == ST_STOPPED && rs_read && stop_on_stall_enable
       && !motion_changed_in && zwait_r == 16'h0002)
      |=> ramp_halt_out [*3] ##1 !ramp_halt_out)
      else $error("resume not after zero wait delay");

   slow_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state_r == ST_RUN && !vel_low_ok && !motor_blocked_in) |=> state_r == ST_RUN)
      else $error("stall stop below lower velocity threshold");

   reg_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (lower_load_threshold == 4'h0 && !standstill_in)
      |=> coil_scale_out == $past(run_current))
      else $error("regulation active with zero lower threshold");

   cur_inc_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (gate_active && load_valid && {1'b0, load} < lower_thr
       && cs_r >= min_cs && cs_r <= run_current)
      |=> coil_scale_out == sat_up($past(cs_r), $past(current_increment_step),
                                   $past(run_current)))
      else $error("wrong current increment");

   cur_dec_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (gate_active && load_valid && {1'b0, load} >= upper_thr
       && current_decrement_rate == 2'h3 && cs_r > min_cs && cs_r <= run_current)
      |=> coil_scale_out == $past(cs_r) - 5'h01)
      else $error("wrong current decrement");

   cs_bound_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (gate_active && !reg_wr_in && $stable(current_r) && $stable(cfg_r) && cs_r >= min_cs
       && cs_r <= run_current) |=> (cs_r >= min_cs && cs_r <= run_current))
      else $error("current scale left its bounds");

endmodule // load_adaptive_current_control

// File: dv/coil_model.sv
/*
 * full step load source standing in for the motor coils.
 * assumes the bench pulses step_in once per full step.
 */
module coil_model (
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   // bench side
   input  wire logic       step_in,
   input  wire logic [9:0] load_in,
   // device side
   output logic      [9:0] load_out,
   output logic            valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // value stands only with its strobe, else it toggles
   always_ff @(posedge clk_sys_in) begin
      valid_out <= rst_b_in & step_in;
      load_out  <= step_in ? load_in : ~load_out;
   end
endmodule // coil_model

// File: dv/load_adaptive_current_control_test.sv
/*
 * bench for the load adaptive current control block.
 * assumes the coil model as load source and registers per package.
 */
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s exp %0h got %0h", n, e, g); end end
module load_adaptive_current_control_test;
   import lacc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, stp = 0, still = 0, blk = 0, ext = 0, chg = 0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [9:0] ldin = 10'h000, ld;
   logic lv, halt, stall;
   logic [22:0] vel = 23'h00_0000, av;
   logic [4:0] cs;
   int num_errors = 0, checked = 0, k;
   coil_model cm_u (.clk_sys_in(clk), .rst_b_in(rst_b), .step_in(stp), .load_in(ldin),
      .load_out(ld), .valid_out(lv));
   load_adaptive_current_control dut_u (.clk_sys_in(clk), .rst_b_in(rst_b),
      .reg_addr_in(adr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .load_measurement_in(ld), .load_valid_in(lv),
      .motor_blocked_in(blk), .ramp_velocity_in(vel), .standstill_in(still),
      .ext_step_mode_in(ext), .motion_changed_in(chg), .ramp_halt_out(halt),
      .actual_velocity_out(av), .coil_scale_out(cs), .stall_flag_out(stall));
   initial forever #50 clk = ~clk;
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) begin adr <= a; wd <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk) begin adr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 q = rdat;
   endtask
   task automatic step(input logic [9:0] v);
      @(posedge clk) begin ldin <= v; stp <= 1'b1; end
      @(posedge clk) stp <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regulate();
      rreg(ADDR_CURRENT);
      `CHK("current", CURRENT_RST, q)
      wreg(ADDR_VLOW, 32'hA);
      wreg(ADDR_UPPER_VELOCITY_THRESHOLD, 32'hC8);
      vel <= 23'h64;
      wreg(ADDR_CFG, 32'h0F01);
      for (k = 0; k < 20; k++) step(10'h40);
      `CHK("half floor", 5'h0F, cs)
      wreg(ADDR_CFG, 32'h1F01);
      for (k = 0; k < 10; k++) step(10'h3FF);
      `CHK("quarter floor", 5'h07, cs)
      for (k = 1; k < 5; k++) begin
         step(10'h1F);
         `CHK("raise", (k < 3) ? 5'h07 + 5'h08 * k[4:0] : 5'h1F, cs)
      end
      @(posedge clk) vel <= 23'h05;
      step(10'h3FF);
      `CHK("slow run", 5'h1F, cs)
      @(posedge clk) still <= 1'b1;
      repeat (3) @(posedge clk);
      #1 `CHK("slow hold", 5'h0A, cs)
      @(posedge clk) begin
         still <= 1'b0;
         vel <= 23'h12C;
      end
      step(10'h3FF);
      `CHK("fast run", 5'h1F, cs)
   endtask
   task automatic t_stall();
      wreg(ADDR_ZWAIT, 32'h2);
      wreg(ADDR_CFG, 32'h4001);
      vel <= 23'h05;
      step(10'h000);
      `CHK("slow no halt", 1'b0, halt)
      @(posedge clk) vel <= 23'h64;
      step(10'h000);
      `CHK("halt", 1'b1, halt)
      `CHK("velocity", 23'h0, av)
      `CHK("stall flag", 1'b1, stall)
      step(10'h1F4);
      rreg(ADDR_DRVSTAT);
      `CHK("status stall", 1'b1, q[DS_STALL_BIT])
      rreg(ADDR_RAMPSTAT);
      `CHK("event", 1'b1, q[RS_EVENT_BIT])
      `CHK("wait halt", 1'b1, halt)
      repeat (6) @(posedge clk);
      #1 `CHK("resumed", 1'b0, halt)
      `CHK("velocity back", 23'h64, av)
      rreg(ADDR_RAMPSTAT);
      `CHK("event clear", 1'b0, q[RS_EVENT_BIT])
   endtask
   task automatic t_filter_block();
      wreg(ADDR_CFG, 32'h2C01);
      for (k = 0; k < 3; k++) step(10'h100);
      `CHK("filtered hold", 5'h1F, cs)
      step(10'h104);
      `CHK("filtered drop", 5'h1E, cs)
      rreg(ADDR_DRVSTAT);
      `CHK("status load", 10'h101, q[DS_LOAD_LSB +: LOAD_W])
      `CHK("status scale", 5'h1E, q[DS_CS_LSB +: CS_W])
      wreg(ADDR_CFG, 32'h4000);
      @(posedge clk) blk <= 1'b1;
      @(posedge clk) blk <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK("blocked halt", 1'b1, halt)
      `CHK("blocked flag", 1'b1, stall)
      @(posedge clk) chg <= 1'b1;
      rreg(ADDR_RAMPSTAT);
      `CHK("blocked event", 1'b1, q[RS_EVENT_BIT])
      `CHK("changed resume", 1'b0, halt)
      @(posedge clk) chg <= 1'b0;
      wreg(ADDR_CFG, 32'h0C01);
      @(posedge clk) begin
         vel <= 23'h05;
         ext <= 1'b1;
      end
      step(10'h3FF);
      `CHK("step dir", 5'h1E, cs)
      @(posedge clk) ext <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK("step dir off", 5'h1F, cs)
   endtask
   task automatic report_and_stop();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #(100 * 5_000);
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_regulate();
      t_stall();
      t_filter_block();
      report_and_stop();
   end
endmodule // load_adaptive_current_control_test
